// File: src/sst_cfg.svh
// constants of the shift, subtract and test execution block
`ifndef SST_CFG_SVH
`define SST_CFG_SVH

// ************************************************************
// register byte addresses on the apb bus
// ************************************************************
`define SST_ADDR_W        12
`define SST_ADR_OPCODE    12'h000
`define SST_ADR_DST       12'h004
`define SST_ADR_SRC       12'h008
`define SST_ADR_FLAGS     12'h00c
`define SST_ADR_STATUS    12'h010
// window pointers keep their printed register index; byte address is four times it
`define SST_IDX_WP_LOW    12'h0d6
`define SST_IDX_WP_HIGH   12'h0d7

// ************************************************************
// opcodes
// ************************************************************
`define SST_OP_SUB_FIRST  8'h22
`define SST_OP_SUB_LAST   8'h26
`define SST_OP_TCM_FIRST  8'h62
`define SST_OP_TCM_LAST   8'h66
`define SST_OP_TM_FIRST   8'h72
`define SST_OP_TM_LAST    8'h76
`define SST_OP_SWAP_R     8'hf0
`define SST_OP_SWAP_IR    8'hf1
`define SST_OP_STOP       8'h7f
`define SST_OP_SRA_R      8'hd0
`define SST_OP_SRA_IR     8'hd1
`define SST_OP_SRP        8'h31
`define SST_OP_SHORT_NIB  4'h2

// ************************************************************
// timing and field positions
// ************************************************************
`define SST_CYC_SHORT     3'd4
`define SST_CYC_LONG      3'd6
`define SST_SEL_LOW_ONLY  2'b10
`define SST_SEL_HIGH_ONLY 2'b01
`define SST_SEL_BOTH      2'b00
`define SST_ST_BUSY       0
`define SST_ST_STOPPED    1
`define SST_ST_ILLEGAL    2
`define SST_ST_WAKE_RST   3
`define SST_ST_WAKE_IRQ   4
`define SST_RST_BYTE      8'h00

`endif

// File: src/sst_pkg.sv
// types and opcode decode of the shift, subtract and test execution block
`include "sst_cfg.svh"
package sst_pkg;

    // flags byte: c z s v d h and two spare bits
    typedef struct packed {
        logic       c;
        logic       z;
        logic       s;
        logic       v;
        logic       d;
        logic       h;
        logic [1:0] spare;
    } sst_flags_t;

    typedef enum {
        SST_K_NONE,
        SST_K_SRA,
        SST_K_SRP,
        SST_K_STOP,
        SST_K_SUB,
        SST_K_SWAP,
        SST_K_TCM,
        SST_K_TM
    } sst_kind_t;

    typedef struct packed {
        logic [7:0] result;
        sst_flags_t flags;
        logic       wr_dst;
    } sst_alu_out_t;

    function automatic sst_kind_t sst_decode(input logic [7:0] op);
        sst_kind_t k;
        k = SST_K_NONE;
        if (op >= `SST_OP_SUB_FIRST && op <= `SST_OP_SUB_LAST)
            k = SST_K_SUB;
        else if (op >= `SST_OP_TCM_FIRST && op <= `SST_OP_TCM_LAST)
            k = SST_K_TCM;
        else if (op >= `SST_OP_TM_FIRST && op <= `SST_OP_TM_LAST)
            k = SST_K_TM;
        else if (op == `SST_OP_SWAP_R || op == `SST_OP_SWAP_IR)
            k = SST_K_SWAP;
        else if (op == `SST_OP_SRA_R || op == `SST_OP_SRA_IR)
            k = SST_K_SRA;
        else if (op == `SST_OP_SRP)
            k = SST_K_SRP;
        else if (op == `SST_OP_STOP)
            k = SST_K_STOP;
        return k;
    endfunction : sst_decode

endpackage : sst_pkg

// File: src/sst_alu.sv
// combinational result and flag logic of the execution block
`timescale 1ns/1ps
module sst_alu
    import sst_pkg::*;
(
    input  wire logic [7:0]   op,
    input  wire logic [7:0]   dst,
    input  wire logic [7:0]   src,
    input  wire sst_flags_t   flags_in,
    output sst_alu_out_t      alu_out
);

    // ************************************************************
    // datapath
    // ************************************************************
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic [7:0] masked;

    // subtraction adds the two's complement, so carry out high means no borrow
    assign diff    = {1'b0, dst} + {1'b0, ~src} + 9'h001;
    assign diff_lo = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;

    // result and flags per operation; unlisted flags hold
    always_comb
    begin
        masked  = 8'h00;
        alu_out = '{result: dst, flags: flags_in, wr_dst: 1'b0};
        case (sst_decode(op))
            SST_K_SRA:
            begin
                alu_out.result  = {dst[7], dst[7:1]};  // RULE1
                alu_out.wr_dst  = 1'b1;
                alu_out.flags.c = dst[0];              // RULE2
                alu_out.flags.z = ({dst[7], dst[7:1]} == 8'h00);
                alu_out.flags.s = dst[7];
                alu_out.flags.v = 1'b0;
            end
            SST_K_SUB:
            begin
                alu_out.result  = diff[7:0];           // RULE10
                alu_out.wr_dst  = 1'b1;
                alu_out.flags.c = ~diff[8];            // RULE11
                alu_out.flags.z = (diff[7:0] == 8'h00);
                alu_out.flags.s = diff[7];
                alu_out.flags.v = (dst[7] != src[7]) && (diff[7] == src[7]);
                alu_out.flags.d = 1'b1;                // RULE12
                alu_out.flags.h = ~diff_lo[4];         // RULE12
            end
            SST_K_SWAP:
            begin
                // undefined carry and overflow are simply left as they were
                alu_out.result  = {dst[3:0], dst[7:4]}; // RULE13
                alu_out.wr_dst  = 1'b1;
                alu_out.flags.z = (dst == 8'h00);      // RULE14
                alu_out.flags.s = dst[3];              // RULE14
            end
            SST_K_TCM:
            begin
                masked          = ~dst & src;          // RULE15
                alu_out.flags.z = (masked == 8'h00);
                alu_out.flags.s = masked[7];
                alu_out.flags.v = 1'b0;
            end
            SST_K_TM:
            begin
                masked          = dst & src;           // RULE16
                alu_out.flags.z = (masked == 8'h00);
                alu_out.flags.s = masked[7];
                alu_out.flags.v = 1'b0;
            end
            default:
            begin
                alu_out.wr_dst = 1'b0;                 // RULE4 RULE6
            end
        endcase
    end

endmodule : sst_alu

// File: src/sst_core.sv
// apb-attached execution unit for shift, pointer, stop, subtract, swap and mask tests
//
// Functional notes
// RULE1 - arithmetic right shift moves bits down, keeps bit 7, copies it to bit 6
// RULE2 - shift: carry gets old bit 0, zero and sign from result, overflow cleared
// RULE3 - pointer select 10 loads bits 7:3 into low pointer, 01 into high
// RULE4 - select 00 loads bits 7:4 into both, bit 3 low cleared, high set
// RULE5 - low pointer at register index d6, high pointer at index d7
// RULE6 - stop is one byte, four cycles, opcode 7f, gates both clocks
// RULE7 - during stop all registers keep their contents
// RULE8 - stop ends only on external reset or external interrupt
// RULE9 - outside party holds reset low until oscillator has stabilised
// RULE10 - subtract stores dst minus src via two's complement add, src untouched
// RULE11 - subtract: carry is borrow, zero, sign, overflow by sign rule
// RULE12 - subtract: decimal flag set, half carry set on low nibble borrow
// RULE13 - nibble swap exchanges low and high halves and writes back
// RULE14 - swap: zero and sign from result, decimal and half carry kept
// RULE15 - inverted mask test ands complement of dst with mask, no write
// RULE16 - mask test ands dst with mask, flags only, no write
// RULE17 - stop finishes its cycles before gating; wake resumes after stop
`timescale 1ns/1ps
`include "sst_cfg.svh"
module sst_core
    import sst_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    srst,
    input  wire logic [`SST_ADDR_W-1:0]  paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    ext_reset_n,
    input  wire logic                    ext_irq,
    output logic                         cpu_clk_en,
    output logic                         sys_clk_en,
    output logic                         stop_mode
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum {
        SST_IDLE,
        SST_EXEC,
        SST_STOPPED
    } sst_state_t;

    typedef struct packed {
        sst_state_t  state;
        logic [2:0]  cnt;
        logic [7:0]  op;
        logic [7:0]  dst;
        logic [7:0]  src;
        sst_flags_t  flags;
        logic [7:0]  wp_low;
        logic [7:0]  wp_high;
        logic        illegal;
        logic        wake_rst;
        logic        wake_irq;
        logic        rst_meta;
        logic        rst_sync;
        logic        irq_meta;
        logic        irq_sync;
        logic [31:0] prdata;
    } sst_regs_t;

    sst_regs_t    s_q;
    sst_regs_t    s_d;
    sst_alu_out_t alu_out;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [`SST_ADDR_W-1:0] sst_idx_addr(
        input logic [`SST_ADDR_W-1:0] idx
    );
        return {idx[`SST_ADDR_W-3:0], 2'b00};
    endfunction : sst_idx_addr

    function automatic logic sst_hit(input logic [`SST_ADDR_W-1:0] a);
        return (a == `SST_ADR_OPCODE) || (a == `SST_ADR_DST) ||
               (a == `SST_ADR_SRC) || (a == `SST_ADR_FLAGS) ||
               (a == `SST_ADR_STATUS) ||
               (a == sst_idx_addr(`SST_IDX_WP_LOW)) ||
               (a == sst_idx_addr(`SST_IDX_WP_HIGH));
    endfunction : sst_hit

    // cycles of the printed format: x2 forms and one-operand ops are short
    function automatic logic [2:0] sst_cycles(input logic [7:0] op);
        sst_kind_t k;
        k = sst_decode(op);
        if (k == SST_K_SUB || k == SST_K_TCM || k == SST_K_TM)
            return (op[3:0] == `SST_OP_SHORT_NIB) ? `SST_CYC_SHORT : `SST_CYC_LONG;
        return `SST_CYC_SHORT;
    endfunction : sst_cycles

    // ************************************************************
    // datapath instance
    // ************************************************************
    sst_alu u_alu (
        .op       (s_q.op),
        .dst      (s_q.dst),
        .src      (s_q.src),
        .flags_in (s_q.flags),
        .alu_out  (alu_out)
    );

    // ************************************************************
    // next state
    // ************************************************************
    logic setup;
    logic wr_ok;
    logic [7:0] wbyte;
    logic [4:0] status;

    assign setup  = psel & ~penable;
    assign wbyte  = pwdata[7:0];
    assign status = {s_q.wake_irq, s_q.wake_rst, s_q.illegal,
                     s_q.state == SST_STOPPED, s_q.state == SST_EXEC};
    // writes are dropped in stop so no bus-written register changes while clocks are gated
    assign wr_ok  = psel & penable & pwrite & sst_hit(paddr)
                  & (s_q.state != SST_STOPPED); // RULE7

    always_comb
    begin
        s_d = s_q;
        // two-flop synchronisers for the wake pins
        s_d.rst_meta = ext_reset_n;
        s_d.rst_sync = s_q.rst_meta;
        s_d.irq_meta = ext_irq;
        s_d.irq_sync = s_q.irq_meta;

        // read data is captured in the setup cycle, so the access needs no wait
        if (setup)
        begin
            case (paddr)
                `SST_ADR_OPCODE:                  s_d.prdata = {24'h000000, s_q.op};
                `SST_ADR_DST:                     s_d.prdata = {24'h000000, s_q.dst};
                `SST_ADR_SRC:                     s_d.prdata = {24'h000000, s_q.src};
                `SST_ADR_FLAGS:                   s_d.prdata = {24'h000000, s_q.flags};
                `SST_ADR_STATUS:                  s_d.prdata = {27'h0000000, status};
                sst_idx_addr(`SST_IDX_WP_LOW):    s_d.prdata = {24'h000000, s_q.wp_low};
                sst_idx_addr(`SST_IDX_WP_HIGH):   s_d.prdata = {24'h000000, s_q.wp_high};
                default:                          s_d.prdata = 32'h00000000;
            endcase
        end

        // plain register writes; the execution commit below takes priority
        if (wr_ok)
        begin
            case (paddr)
                `SST_ADR_DST:                   s_d.dst     = wbyte;
                `SST_ADR_SRC:                   s_d.src     = wbyte;
                `SST_ADR_FLAGS:                 s_d.flags   = sst_flags_t'(wbyte);
                sst_idx_addr(`SST_IDX_WP_LOW):  s_d.wp_low  = wbyte; // RULE5
                sst_idx_addr(`SST_IDX_WP_HIGH): s_d.wp_high = wbyte; // RULE5
                default:                        s_d.op      = s_q.op;
            endcase
        end

        case (s_q.state)
            SST_IDLE:
            begin
                if (wr_ok && paddr == `SST_ADR_OPCODE)
                begin
                    s_d.op      = wbyte;
                    s_d.illegal = (sst_decode(wbyte) == SST_K_NONE);
                    if (sst_decode(wbyte) != SST_K_NONE)
                    begin
                        s_d.cnt   = sst_cycles(wbyte) - 3'd1;
                        s_d.state = SST_EXEC;
                    end
                end
            end
            SST_EXEC:
            begin
                if (s_q.cnt != 3'd0)
                begin
                    s_d.cnt = s_q.cnt - 3'd1;
                end
                else
                begin
                    // commit on the last cycle of the instruction
                    s_d.flags = alu_out.flags;
                    if (alu_out.wr_dst)
                        s_d.dst = alu_out.result; // RULE10 RULE13
                    if (sst_decode(s_q.op) == SST_K_SRP)
                    begin
                        case (s_q.src[1:0])
                            `SST_SEL_LOW_ONLY:
                                s_d.wp_low[7:3] = s_q.src[7:3]; // RULE3
                            `SST_SEL_HIGH_ONLY:
                                s_d.wp_high[7:3] = s_q.src[7:3]; // RULE3
                            `SST_SEL_BOTH:
                            begin
                                s_d.wp_low[7:3]  = {s_q.src[7:4], 1'b0}; // RULE4
                                s_d.wp_high[7:3] = {s_q.src[7:4], 1'b1}; // RULE4
                            end
                            default:
                                s_d.wp_low = s_q.wp_low;
                        endcase
                    end
                    // stop gates the clocks only after its own four cycles
                    if (sst_decode(s_q.op) == SST_K_STOP)
                    begin
                        s_d.state    = SST_STOPPED; // RULE6 RULE17
                        s_d.wake_rst = 1'b0;
                        s_d.wake_irq = 1'b0;
                    end
                    else
                    begin
                        s_d.state = SST_IDLE;
                    end
                end
            end
            SST_STOPPED:
            begin
                // reset must stay low through oscillator settling; we leave on first sight
                if (!s_q.rst_sync || s_q.irq_sync)
                begin
                    s_d.state    = SST_IDLE; // RULE8 RULE9 RULE17
                    s_d.wake_rst = ~s_q.rst_sync;
                    s_d.wake_irq = s_q.irq_sync;
                end
            end
            default:
            begin
                s_d.state = SST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s_q          <= '0;
            s_q.state    <= SST_IDLE;
            s_q.flags    <= sst_flags_t'(`SST_RST_BYTE);
            s_q.rst_meta <= 1'b1;
            s_q.rst_sync <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata     = s_q.prdata;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~sst_hit(paddr);
    assign stop_mode  = (s_q.state == SST_STOPPED);
    assign cpu_clk_en = ~stop_mode; // RULE6
    assign sys_clk_en = ~stop_mode; // RULE6

endmodule : sst_core

// File: tb/sst_core_assertions.sv
// concurrent checks on the ports of the execution block
`timescale 1ns/1ps
`include "sst_cfg.svh"
module sst_core_assertions
    import sst_pkg::*;
(
    input wire logic                   mclk,
    input wire logic                   srst,
    input wire logic [`SST_ADDR_W-1:0] paddr,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   ext_reset_n,
    input wire logic                   ext_irq,
    input wire logic                   cpu_clk_en,
    input wire logic                   sys_clk_en,
    input wire logic                   stop_mode
);
    // ************************************************************
    // helper: cycles since a wake pin was last active
    // ************************************************************
    logic [2:0] quiet_q;
    logic [2:0] quiet_d;

    // saturating, so long stops do not wrap the count
    always_comb
        if (!ext_reset_n || ext_irq)
            quiet_d = 3'd0;
        else
            quiet_d = (quiet_q == 3'd7) ? quiet_q : quiet_q + 3'd1;

    always_ff @(posedge mclk)
        quiet_q <= srst ? 3'd0 : quiet_d;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("error outside access");
    property p_err_map; psel && penable && paddr == `SST_ADR_DST |-> !pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("error on mapped address");
    property p_hi_zero; prdata[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits set");
    property p_gate; stop_mode |-> !cpu_clk_en && !sys_clk_en; endproperty
    a_gate: assert property (p_gate) else $error("clocks run while stopped");
    property p_run; !stop_mode |-> cpu_clk_en && sys_clk_en; endproperty
    a_run: assert property (p_run) else $error("clocks gated outside stop");
    property p_stop_lat;
        psel && penable && pwrite && paddr == `SST_ADR_OPCODE
            && pwdata[7:0] == `SST_OP_STOP && !stop_mode
            |=> !stop_mode [*3] ##[1:2] stop_mode;
    endproperty
    a_stop_lat: assert property (p_stop_lat) else $error("stop entry timing");
    property p_hold; stop_mode && quiet_q >= 3'd5 |=> stop_mode; endproperty
    a_hold: assert property (p_hold) else $error("stop left without wake");
    property p_wake_irq; stop_mode && ext_irq |-> ##[1:5] !stop_mode; endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("no wake on irq");
    property p_wake_rst; stop_mode && !ext_reset_n |-> ##[1:5] !stop_mode; endproperty
    a_wake_rst: assert property (p_wake_rst) else $error("no wake on reset pin");
endmodule : sst_core_assertions

bind sst_core sst_core_assertions u_chk (
    .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset_n(ext_reset_n), .ext_irq(ext_irq),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .stop_mode(stop_mode)
);

// File: tb/testbench.sv
// self-checking bench of the shift, subtract and test execution block
`timescale 1ns/1ps
`include "sst_cfg.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench
    import sst_pkg::*;
;
    // ************************************************************
    // signals and tables
    // ************************************************************
    localparam logic [11:0] A_LOW        = `SST_IDX_WP_LOW << 2;
    localparam logic [11:0] A_HIGH       = `SST_IDX_WP_HIGH << 2;
    localparam int          STAB         = 8; // reset pin held low this long
    localparam logic [7:0]  SUB_D [5]    = '{8'h12, 8'h21, 8'h21, 8'h03, 8'h08};
    localparam logic [7:0]  SUB_S [5]    = '{8'h03, 8'h90, 8'h65, 8'h03, 8'h09};
    logic                   mclk         = 1'b0;
    logic                   srst         = 1'b1;
    logic                   psel         = 1'b0;
    logic                   penable      = 1'b0;
    logic                   pwrite       = 1'b0;
    logic [11:0]            paddr        = 12'h000;
    logic [31:0]            pwdata       = 32'h0;
    logic                   ext_reset_n  = 1'b1;
    logic                   ext_irq      = 1'b0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   cpu_clk_en;
    logic                   sys_clk_en;
    logic                   stop_mode;
    logic [31:0]            q;
    logic                   e;
    logic [7:0]             rr;
    logic [7:0]             rf;
    int                     err_count    = 0;
    int                     samples_checked = 0;

    // free-running clock, 4 ns period
    always #2 mclk = ~mclk;

    sst_core dut (
        .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n(ext_reset_n), .ext_irq(ext_irq),
        .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .stop_mode(stop_mode)
    );

    // one transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded poll of the busy bit; leaves status in q
    task automatic wait_idle;
        apb(1'b0, `SST_ADR_STATUS, 8'h00);
        repeat (30)
            if (q[`SST_ST_BUSY] !== 1'b0)
                apb(1'b0, `SST_ADR_STATUS, 8'h00);
        `CHK("busy", 1'b0, q[`SST_ST_BUSY])
    endtask : wait_idle

    task automatic exec(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s,
                        input logic [7:0] f);
        apb(1'b1, `SST_ADR_DST, d);
        apb(1'b1, `SST_ADR_SRC, s);
        apb(1'b1, `SST_ADR_FLAGS, f);
        apb(1'b1, `SST_ADR_OPCODE, op);
        wait_idle();
        apb(1'b0, `SST_ADR_FLAGS, 8'h00);
        rf = q[7:0];
        apb(1'b0, `SST_ADR_DST, 8'h00);
        rr = q[7:0];
    endtask : exec

    task automatic t_err;
        apb(1'b0, 12'h100, 8'h00);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, q)
        apb(1'b1, `SST_ADR_OPCODE, 8'h00);
        wait_idle();
        `CHK("illegal", 1'b1, q[`SST_ST_ILLEGAL])
        $display("t_err done");
    endtask : t_err

    // a bit-0 one case as well, so a stuck carry shows
    task automatic t_sra;
        logic [7:0] d;
        for (int i = 0; i < 2; i++)
        begin
            d = i ? 8'h01 : 8'h9a;
            exec(8'(`SST_OP_SRA_R + i), d, 8'h00, 8'h9c);
            `CHK("sra res", {d[7], d[7:1]}, rr)
            `CHK("sra flags", {d[0], ~|d[7:1], d[7], 3'b011}, rf[7:2])
        end
        $display("t_sra done");
    endtask : t_sra

    task automatic t_sub;
        logic [7:0] d, s, r;
        for (int i = 0; i < 5; i++)
        begin
            d = SUB_D[i];
            s = SUB_S[i];
            r = d - s;
            exec(8'(`SST_OP_SUB_FIRST + i), d, s, 8'h00);
            `CHK("sub res", r, rr)
            `CHK("sub czsv", {s > d, ~|r, r[7], (d[7] ^ s[7]) & (r[7] ~^ s[7])}, rf[7:4])
            `CHK("sub dh", {1'b1, d[3:0] < s[3:0]}, rf[3:2])
            apb(1'b0, `SST_ADR_SRC, 8'h00);
            `CHK("sub src", s, q[7:0])
        end
        $display("t_sub done");
    endtask : t_sub

    task automatic t_swap;
        logic [7:0] d;
        for (int i = 0; i < 2; i++)
        begin
            d = i ? 8'ha4 : 8'h3e;
            exec(8'(`SST_OP_SWAP_R + i), d, 8'h00, i ? 8'h04 : 8'h08);
            `CHK("swap res", {d[3:0], d[7:4]}, rr)
            `CHK("swap zs", {d == 8'h00, d[3]}, rf[6:5])
            `CHK("swap dh", i ? 2'b01 : 2'b10, rf[3:2])
        end
        $display("t_swap done");
    endtask : t_swap

    task automatic t_mask;
        logic [7:0] d, s, v, op;
        for (int i = 0; i < 10; i++)
        begin
            d = i[0] ? 8'h2b : 8'hc7;
            s = i[0] ? 8'hd4 : 8'h02;
            v = (i < 5) ? (~d & s) : (d & s);
            op = (i < 5) ? 8'(`SST_OP_TCM_FIRST + i) : 8'(`SST_OP_TM_FIRST + i - 5);
            exec(op, d, s, 8'h9c);
            `CHK("mask dst", d, rr)
            `CHK("mask flags", {1'b1, v == 8'h00, v[7], 3'b011}, rf[7:2])
            apb(1'b0, `SST_ADR_SRC, 8'h00);
            `CHK("mask src", s, q[7:0])
        end
        $display("t_mask done");
    endtask : t_mask

    task automatic srp_step(input logic [7:0] s, input logic [7:0] lo, input logic [7:0] hi);
        exec(`SST_OP_SRP, 8'h00, s, 8'hfc);
        `CHK("srp flags", 8'hfc, rf)
        apb(1'b0, A_LOW, 8'h00);
        `CHK("ptr low", lo, q[7:0])
        apb(1'b0, A_HIGH, 8'h00);
        `CHK("ptr high", hi, q[7:0])
    endtask : srp_step

    task automatic t_srp;
        srp_step(8'h40, 8'h40, 8'h48);
        srp_step(8'h56, 8'h50, 8'h48);
        srp_step(8'h6d, 8'h50, 8'h68);
        srp_step(8'hfb, 8'h50, 8'h68);
        $display("t_srp done");
    endtask : t_srp

    // first wake by interrupt, second by the reset pin
    task automatic t_stop;
        for (int i = 0; i < 2; i++)
        begin
            exec(`SST_OP_STOP, 8'h5a, 8'h33, 8'h9c);
            `CHK("stop flags", 8'h9c, rf)
            `CHK("stop pins", 3'b100, {stop_mode, cpu_clk_en, sys_clk_en})
            apb(1'b1, `SST_ADR_DST, 8'ha5);
            repeat (20)
                @(posedge mclk);
            apb(1'b0, `SST_ADR_DST, 8'h00);
            `CHK("stop dst", 8'h5a, q[7:0])
            `CHK("stop held", 1'b1, stop_mode)
            if (i)
                ext_reset_n <= 1'b0;
            else
                ext_irq <= 1'b1;
            repeat (STAB)
                @(posedge mclk);
            ext_reset_n <= 1'b1;
            ext_irq     <= 1'b0;
            apb(1'b0, `SST_ADR_STATUS, 8'h00);
            `CHK("wake src", i ? 2'b01 : 2'b10, q[4:3])
            `CHK("wake pins", 3'b011, {stop_mode, cpu_clk_en, sys_clk_en})
            apb(1'b0, `SST_ADR_DST, 8'h00);
            `CHK("wake dst", 8'h5a, q[7:0])
        end
        $display("t_stop done");
    endtask : t_stop

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // main sequence
    initial
    begin
        repeat (20)
            @(posedge mclk);
        srst <= 1'b0;
        t_err();
        t_sra();
        t_sub();
        t_swap();
        t_mask();
        t_srp();
        t_stop();
        end_sim();
    end

    // watchdog, far beyond the fewer than one thousand cycles the tests need
    initial
    begin
        repeat (20000)
            @(posedge mclk);
        err_count++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : testbench
